/* File: bench/sfc_filter_config_bench.sv */
`timescale 1ns/1ps
module sfc_filter_config_bench;
  // Drive and observation signals of the block.
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        direct_decimation_select;
  logic [14:0] decimation_value;
  logic        sinc3_active;
  logic        post_filter_active;
  logic [2:0]  post_filter_select;
  logic [4:0]  output_rate_code;
  logic [24:0] rate_x100;
  logic        rate_valid;
  logic [6:0]  rejection_db;
  logic [15:0] settle_us;
  logic        config_undefined;
  int          fail_count = 0;
  int          check_count = 0;

  // Block under test with every port driven or watched.
  sfc_filter_config sfc_filter_config_inst (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .direct_decimation_select(direct_decimation_select), .decimation_value(decimation_value),
    .sinc3_active(sinc3_active), .post_filter_active(post_filter_active),
    .post_filter_select(post_filter_select), .output_rate_code(output_rate_code),
    .rate_x100(rate_x100), .rate_valid(rate_valid), .rejection_db(rejection_db),
    .settle_us(settle_us), .config_undefined(config_undefined));

  // Free-running 50 MHz clock.
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // One write cycle; returns at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // One read cycle; data must stand one cycle only and then drop to zero.
  task automatic rd(input logic [7:0] a, input logic [15:0] expv);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 check(32'(reg_rdata), 32'(expv));
    @(posedge ref_clk);
    #1 check(32'(reg_rdata), 32'h0000_0000);
  endtask : rd

  // Lets the decoded outputs follow the last write.
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // Direct decimation overrides every other field.
  task automatic t_direct();
    wr(8'h2b, 16'hffff);
    settle();
    check(32'({direct_decimation_select, sinc3_active}), 32'h3);
    check(32'(decimation_value), 32'h0f7f);
    check(32'({post_filter_active, rate_valid, output_rate_code}), 32'h0);
    rd(8'h2b, 16'h8f7f);
    wr(8'h2b, 16'h8123);
    settle();
    check(32'(decimation_value), 32'h0123);
  endtask : t_direct

  // One post-filter code with its rate, rejection and settling.
  task automatic pf(input logic [2:0] c, input logic [24:0] r, input logic [6:0] j,
                    input logic [15:0] s);
    wr(8'h2b, {4'h0, 1'b1, c, 8'h00});
    settle();
    check(32'({post_filter_active, post_filter_select, rate_valid}), 32'({1'b1, c, 1'b1}));
    check(32'(rate_x100), 32'(r));
    check(32'({rejection_db, settle_us}), 32'({j, s}));
  endtask : pf

  // All four defined post-filter codes, then enable off, then the wrong filter type.
  task automatic t_post();
    pf(3'b010, 25'h0000a8c, 7'h2f, 16'h8f5c);
    pf(3'b011, 25'h00009c4, 7'h3e, 16'h9c40);
    pf(3'b101, 25'h00007d0, 7'h56, 16'hc350);
    pf(3'b110, 25'h0000683, 7'h5c, 16'hea60);
    wr(8'h2b, 16'h0200);
    settle();
    check(32'({post_filter_active, rejection_db}), 32'h0);
    check(32'(rate_x100), 32'h017d7840);
    wr(8'h2b, 16'h0a60);
    settle();
    check(32'({post_filter_active, sinc3_active}), 32'h1);
  endtask : t_post

  // Rate codes, an unlisted code and an unlisted filter type.
  task automatic t_rate();
    logic [4:0]  codes [3] = '{5'h00, 5'h01, 5'h04};
    logic [24:0] rates [3] = '{25'h17d7840, 25'h0bebc20, 25'h02625a0};
    for (int i = 0; i < 3; i++) begin
      wr(8'h2b, {11'h000, codes[i]});
      settle();
      check(32'({rate_valid, output_rate_code, sinc3_active}), 32'({1'b1, codes[i], 1'b0}));
      check(32'(rate_x100), 32'(rates[i]));
    end
    wr(8'h2b, 16'h001f);
    settle();
    check(32'({config_undefined, rate_valid}), 32'h2);
    wr(8'h2b, 16'h0020);
    settle();
    check(32'(config_undefined), 32'h1);
    wr(8'h2b, 16'h0800);
    settle();
    check(32'({config_undefined, rate_valid, post_filter_active}), 32'h5);
    wr(8'h2b, 16'h0060);
    settle();
    check(32'({sinc3_active, config_undefined, rate_valid}), 32'h5);
    check(32'(rate_x100), 32'h017d7840);
  endtask : t_rate

  // Unmapped address, reserved bits and a read straight after a write.
  task automatic t_bus();
    wr(8'h2b, 16'h0805);
    wr(8'h2a, 16'h0001);
    rd(8'h2b, 16'h0805);
    rd(8'h2a, 16'h0000);
    wr(8'h2b, 16'h7a85);
    reg_rd   <= 1'b1;
    reg_addr <= 8'h2b;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 check(32'(reg_rdata), 32'h0a05);
  endtask : t_bus

  // A reset in mid-run brings the register back to zero.
  task automatic t_rst();
    wr(8'h2b, 16'h0a43);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check(32'({post_filter_active, rate_valid, reg_rdata}), 32'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h2b, 16'h0000);
  endtask : t_rst

  ////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (7) @(posedge ref_clk);
    #1 check(32'({rate_valid, sinc3_active, rate_x100}), 32'h0);
    @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    check(32'({rate_valid, rate_x100}), 32'h037d7840);
    rd(8'h2b, 16'h0000);
    t_direct();
    t_post();
    t_rate();
    t_bus();
    t_rst();
    end_sim();
  end
endmodule : sfc_filter_config_bench

/* File: core/sfc_cfg_if.sv */
`timescale 1ns/1ps
// Decoded configuration handed from the register to the decoders.
interface sfc_cfg_if;
  logic [15:0] raw;
  logic        direct;
  logic [24:0] rate_x100;
  logic        rate_valid;
  modport src (output raw, output direct, input rate_x100, input rate_valid);
  modport dec (input raw, input direct, output rate_x100, output rate_valid);
endinterface : sfc_cfg_if

/* File: core/sfc_filter_config.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - The 16-bit setup-3 filter register sits at address 0x2b and resets to zero.
// - With the direct decimation bit set, bits 14:0 become a sinc3 decimation value; the write mask still stores bits 14:12 and 7 as zero.
// - In direct mode the single-channel rate is the modulator rate over 32 times bits 14:0; the block gives no rate then (rate_valid low).
// - Bits 14:12 are reserved, read as zero and must be written as zero.
// - Bit 7 is reserved, reads as zero and must be written as zero.
// - Bit 11 turns the 50/60 Hz post filter on when set, in table mode with sinc5 plus sinc1 only, and off when clear.
// - Post-filter code 010 gives 27 SPS, 47 dB rejection and 36.7 ms settling.
// - Post-filter code 011 gives 25 SPS, 62 dB rejection and 40 ms settling.
// - Post-filter code 101 gives 20 SPS, 86 dB rejection and 50 ms settling.
// - Post-filter code 110 gives 16.67 SPS, 92 dB rejection and 60 ms settling.
// - Filter type 00 selects sinc5 plus sinc1 and 11 selects sinc3.
// - Output rate code 00000 gives 250,000 samples per second.
// - Codes 00001 and 00100 give 125,000 and 25,000 samples per second.
module sfc_filter_config
  import sfc_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Decoded configuration for the filter datapath.
  output logic             direct_decimation_select,
  output logic [14:0]      decimation_value,
  output logic             sinc3_active,
  output logic             post_filter_active,
  output logic [2:0]       post_filter_select,
  output logic [4:0]       output_rate_code,
  output logic [24:0]      rate_x100,
  output logic             rate_valid,
  output logic [6:0]       rejection_db,
  output logic [15:0]      settle_us,
  output logic             config_undefined
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] setup3_filter_config_q;
  logic        wr_hit;
  logic [6:0]  pf_rej;
  logic [15:0] pf_settle;
  logic        pf_valid;
  logic        post_on;
  logic        type_ok;

  sfc_cfg_if cfg_bus ();

  // The register write: reserved bits are forced to zero.
  assign wr_hit = reg_wr && (reg_addr == SFC_ADDR_FILT3);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      setup3_filter_config_q <= SFC_RESET_FILT3;
    end else if (wr_hit) begin
      setup3_filter_config_q <= reg_wdata & SFC_WRITABLE_MASK;
    end
  end

  // Read data stands one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && reg_addr == SFC_ADDR_FILT3) begin
      reg_rdata <= setup3_filter_config_q;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoders.
  assign cfg_bus.raw    = setup3_filter_config_q;
  assign cfg_bus.direct = setup3_filter_config_q[SFC_DIRECT_BIT];

  sfc_rate_decode u_rate (
    .cfg (cfg_bus.dec)
  );

  sfc_post_decode u_post (
    .sel       (setup3_filter_config_q[SFC_POST_SEL_HI:SFC_POST_SEL_LO]),
    .rej_db    (pf_rej),
    .settle_us (pf_settle),
    .valid     (pf_valid)
  );

  // Post filter acts only in table mode with sinc5 plus sinc1.
  assign type_ok = setup3_filter_config_q[SFC_TYPE_HI:SFC_TYPE_LO] == SFC_SINC5_SINC1;
  assign post_on = !setup3_filter_config_q[SFC_DIRECT_BIT] &&
                   setup3_filter_config_q[SFC_POST_EN_BIT] && type_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs for the filter datapath.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      direct_decimation_select <= 1'b0;
      decimation_value         <= 15'h0000;
      sinc3_active             <= 1'b0;
      post_filter_active       <= 1'b0;
      post_filter_select       <= 3'h0;
      output_rate_code         <= 5'h00;
    end else begin
      direct_decimation_select <= setup3_filter_config_q[SFC_DIRECT_BIT];
      decimation_value         <= setup3_filter_config_q[SFC_DIRECT_BIT] ?
                                  setup3_filter_config_q[14:0] : 15'h0000;
      // Direct mode always runs sinc3; otherwise code 11 selects it.
      sinc3_active             <= setup3_filter_config_q[SFC_DIRECT_BIT] ||
                                  setup3_filter_config_q[SFC_TYPE_HI:SFC_TYPE_LO]
                                  == SFC_SINC3;
      post_filter_active       <= post_on;
      post_filter_select       <= post_on ?
                                  setup3_filter_config_q[SFC_POST_SEL_HI:SFC_POST_SEL_LO] : 3'h0;
      output_rate_code         <= setup3_filter_config_q[SFC_DIRECT_BIT] ?
                                  5'h00 : setup3_filter_config_q[SFC_RATE_HI:SFC_RATE_LO];
    end
  end

  // Rate and post-filter figures, and the undefined-setting flag.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_x100        <= 25'd0;
      rate_valid       <= 1'b0;
      rejection_db     <= 7'd0;
      settle_us        <= 16'd0;
      config_undefined <= 1'b0;
    end else begin
      rate_x100        <= cfg_bus.rate_x100;
      rate_valid       <= cfg_bus.rate_valid;
      rejection_db     <= post_on ? pf_rej : 7'd0;
      settle_us        <= post_on ? pf_settle : 16'd0;
      // Outside direct mode: type codes 01 and 10, unlisted post-filter codes while the filter acts, else unlisted rate codes.
      config_undefined <= !setup3_filter_config_q[SFC_DIRECT_BIT] &&
                          (!cfg_bus.rate_valid ||
                           setup3_filter_config_q[SFC_TYPE_HI] !=
                           setup3_filter_config_q[SFC_TYPE_LO] ||
                           (post_on && !pf_valid));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  reset_value_a: assert property (@(posedge ref_clk)
    $past(rst) |-> setup3_filter_config_q == SFC_RESET_FILT3)
    else $error("register not zero after reset");

  reserved_hi_a: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == SFC_ADDR_FILT3 |=> reg_rdata[14:12] == 3'b000)
    else $error("reserved bits 14:12 read nonzero");

  reserved_seven_a: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == SFC_ADDR_FILT3 |=> reg_rdata[7] == 1'b0)
    else $error("reserved bit 7 read nonzero");

  readback_value_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit ##1 (reg_rd && reg_addr == SFC_ADDR_FILT3 && !reg_wr)
    |=> reg_rdata == ($past(reg_wdata, 2) & SFC_WRITABLE_MASK))
    else $error("read back differs from write");

  direct_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata[15] |=> ##1 direct_decimation_select && sinc3_active
      && !post_filter_active && !rate_valid)
    else $error("direct mode did not override options");

  decim_value_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata[15] |=> ##1
      decimation_value == ($past(reg_wdata[14:0], 2) & SFC_WRITABLE_MASK[14:0]))
    else $error("decimation value wrong");

  post_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    post_filter_active |-> $past(setup3_filter_config_q[11])
      && $past(setup3_filter_config_q[6:5]) == 2'b00)
    else $error("post filter active without enable");

  rate_top_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0000 |=> ##1 rate_x100 == 25'd25000000 && rate_valid)
    else $error("rate code 0 not 250000");

  post_27_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0a00 |=> ##1 rejection_db == 7'd47
      && settle_us == 16'd36700 && rate_x100 == 25'd2700)
    else $error("post filter 010 figures wrong");

  sinc3_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0060 |=> ##1 sinc3_active && !config_undefined)
    else $error("sinc3 not selected");

  ////////////////////////////////////////////////////////////////////////////////
  // Post-filter checks.

  // Code 011 with the post filter on gives its own figures.
  post_25_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0b00 |=> ##1 rejection_db == 7'h3e
      && settle_us == 16'h9c40 && rate_x100 == 25'h00009c4)
    else $error("post filter 011 figures wrong");

  // Code 101 with the post filter on gives its own figures.
  post_20_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0d00 |=> ##1 rejection_db == 7'h56
      && settle_us == 16'hc350 && rate_x100 == 25'h00007d0)
    else $error("post filter 101 figures wrong");

  // Code 110 with the post filter on gives its own figures.
  post_1667_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0e00 |=> ##1 rejection_db == 7'h5c
      && settle_us == 16'hea60 && rate_x100 == 25'h0000683)
    else $error("post filter 110 figures wrong");

  // The datapath sees the stored select code while the filter acts.
  post_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    post_filter_active |-> post_filter_select ==
      $past(setup3_filter_config_q[SFC_POST_SEL_HI:SFC_POST_SEL_LO]))
    else $error("post filter select not passed on");

  // An idle post filter must not leak stale figures downstream.
  post_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !post_filter_active |-> rejection_db == 7'h00 && settle_us == 16'h0000
      && post_filter_select == 3'h0)
    else $error("idle post filter shows figures");

  // The enable alone is not enough while sinc3 is chosen.
  post_type_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata[SFC_POST_EN_BIT] &&
      reg_wdata[SFC_TYPE_HI:SFC_TYPE_LO] == SFC_SINC3 |=> ##1 !post_filter_active)
    else $error("post filter acts with sinc3");

  // A defined post filter always reports nonzero figures.
  settle_valid_a: assert property (@(posedge ref_clk) disable iff (rst)
    post_filter_active && rate_valid |-> rejection_db != 7'h00
      && settle_us != 16'h0000)
    else $error("defined post filter without figures");

  ////////////////////////////////////////////////////////////////////////////////
  // Output rate code and undefined-setting checks.

  // Code 00001 halves the top rate.
  rate_half_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0001 |=> ##1 rate_valid && rate_x100 == 25'h0bebc20)
    else $error("rate code 1 not 125000");

  // Code 00100 gives a tenth of the top rate.
  rate_tenth_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0004 |=> ##1 rate_valid && rate_x100 == 25'h02625a0)
    else $error("rate code 4 not 25000");

  // Outside direct mode the stored rate code reaches the datapath.
  rate_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) && !direct_decimation_select |-> output_rate_code ==
      $past(setup3_filter_config_q[SFC_RATE_HI:SFC_RATE_LO]))
    else $error("rate code not passed on");

  // An unlisted rate code is flagged and gives no rate.
  undef_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h001f |=> ##1 config_undefined && !rate_valid)
    else $error("unlisted rate code not flagged");

  // Filter type 01 has no meaning and is flagged.
  undef_type_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && !reg_wdata[SFC_DIRECT_BIT] &&
      reg_wdata[SFC_TYPE_HI:SFC_TYPE_LO] == 2'h1 |=> ##1 config_undefined)
    else $error("unlisted filter type not flagged");

  // Post filter on with an unlisted code is flagged.
  undef_post_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && reg_wdata == 16'h0800 |=> ##1 config_undefined && !rate_valid)
    else $error("unlisted post filter not flagged");

  ////////////////////////////////////////////////////////////////////////////////
  // Filter type and direct mode checks.

  // Type 00 outside direct mode never runs sinc3.
  sinc5_type_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && !reg_wdata[SFC_DIRECT_BIT] &&
      reg_wdata[SFC_TYPE_HI:SFC_TYPE_LO] == SFC_SINC5_SINC1 |=> ##1 !sinc3_active)
    else $error("sinc3 runs with type 00");

  // Direct mode always means sinc3 and no table rate.
  direct_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    direct_decimation_select |-> sinc3_active && !post_filter_active && !rate_valid)
    else $error("direct mode runs table options");

  // Direct mode hides every table field from the datapath.
  direct_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    direct_decimation_select |-> output_rate_code == 5'h00 && post_filter_select == 3'h0
      && rejection_db == 7'h00 && settle_us == 16'h0000 && !config_undefined)
    else $error("direct mode shows table fields");

  // The decimation value follows the stored low bits.
  decim_direct_a: assert property (@(posedge ref_clk) disable iff (rst)
    direct_decimation_select |-> decimation_value == $past(setup3_filter_config_q[14:0]))
    else $error("decimation value not stored bits");

  // Table mode gives no decimation value.
  table_decim_a: assert property (@(posedge ref_clk) disable iff (rst)
    !direct_decimation_select |-> decimation_value == 15'h0000)
    else $error("decimation value outside direct mode");

  ////////////////////////////////////////////////////////////////////////////////
  // Register and read port checks.

  // Reserved high bits never reach the register.
  mask_hi_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit |=> setup3_filter_config_q[14:12] == 3'h0)
    else $error("reserved bits 14:12 stored");

  // Reserved bit 7 never reaches the register.
  mask_seven_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit |=> !setup3_filter_config_q[7])
    else $error("reserved bit 7 stored");

  // Only a write to this address changes the register.
  hold_value_a: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_hit |=> $stable(setup3_filter_config_q))
    else $error("register changed without a write");

  // A read returns the register as it stood at the strobe.
  mapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == SFC_ADDR_FILT3 |=> reg_rdata == $past(setup3_filter_config_q))
    else $error("read data not register value");

  // Other addresses read as zero.
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr != SFC_ADDR_FILT3 |=> reg_rdata == 16'h0000)
    else $error("unmapped address read nonzero");

  // Read data stands for one cycle only.
  read_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without a strobe");

  // Read data and the single-bit flags are cleared by reset.
  reset_outputs_a: assert property (@(posedge ref_clk)
    $past(rst) |-> reg_rdata == 16'h0000 && !rate_valid && !sinc3_active
      && !direct_decimation_select && !post_filter_active && !config_undefined)
    else $error("outputs not cleared by reset");

  direct_seen_c: cover property (@(posedge ref_clk) direct_decimation_select);
  post_seen_c:   cover property (@(posedge ref_clk) post_filter_active && rate_valid);
  undef_seen_c:  cover property (@(posedge ref_clk) config_undefined);
  sinc3_seen_c:  cover property (@(posedge ref_clk) sinc3_active && !direct_decimation_select);
  read_seen_c:   cover property (@(posedge ref_clk) reg_rdata != 16'h0000);

endmodule : sfc_filter_config

/* File: core/sfc_pkg.sv */
package sfc_pkg;

  // Register map and field layout.
  localparam logic [7:0]  SFC_ADDR_FILT3     = 8'h2b;
  localparam logic [15:0] SFC_RESET_FILT3    = 16'h0000;
  localparam logic [15:0] SFC_WRITABLE_MASK  = 16'h8f7f;
  localparam int          SFC_DIRECT_BIT     = 15;
  localparam int          SFC_POST_EN_BIT    = 11;
  localparam int          SFC_POST_SEL_HI    = 10;
  localparam int          SFC_POST_SEL_LO    = 8;
  localparam int          SFC_TYPE_HI        = 6;
  localparam int          SFC_TYPE_LO        = 5;
  localparam int          SFC_RATE_HI        = 4;
  localparam int          SFC_RATE_LO        = 0;
  localparam int          SFC_DECIM_MULT     = 32;

  // Filter type codes.
  typedef enum logic [1:0] {
    SFC_SINC5_SINC1 = 2'b00,
    SFC_SINC3       = 2'b11
  } sfc_type_e;

  // Post-filter codes.
  localparam logic [2:0] SFC_PF_27   = 3'b010;
  localparam logic [2:0] SFC_PF_25   = 3'b011;
  localparam logic [2:0] SFC_PF_20   = 3'b101;
  localparam logic [2:0] SFC_PF_1667 = 3'b110;

  // Settling times in microseconds of each post filter.
  localparam logic [15:0] SFC_SETTLE_27_US   = 16'd36700;
  localparam logic [15:0] SFC_SETTLE_25_US   = 16'd40000;
  localparam logic [15:0] SFC_SETTLE_20_US   = 16'd50000;
  localparam logic [15:0] SFC_SETTLE_1667_US = 16'd60000;

  // Output rates in samples per second times one hundred.
  localparam logic [24:0] SFC_RATE_27   = 25'd2700;
  localparam logic [24:0] SFC_RATE_25   = 25'd2500;
  localparam logic [24:0] SFC_RATE_20   = 25'd2000;
  localparam logic [24:0] SFC_RATE_1667 = 25'd1667;

  // Rejection in dB of each post filter.
  localparam logic [6:0] SFC_REJ_27   = 7'd47;
  localparam logic [6:0] SFC_REJ_25   = 7'd62;
  localparam logic [6:0] SFC_REJ_20   = 7'd86;
  localparam logic [6:0] SFC_REJ_1667 = 7'd92;

endpackage : sfc_pkg

/* File: core/sfc_post_decode.sv */
`timescale 1ns/1ps
// Gives rejection and settling figures of the selected post filter.
module sfc_post_decode
  import sfc_pkg::*;
(
  // Post-filter select code.
  input  wire logic [2:0]  sel,
  // Figures; valid low for undefined codes.
  output logic [6:0]       rej_db,
  output logic [15:0]      settle_us,
  output logic             valid
);

  // Decode the four defined post filters.
  always_comb begin
    unique case (sel)
      SFC_PF_27:   {valid, rej_db, settle_us} = {1'b1, SFC_REJ_27, SFC_SETTLE_27_US};
      SFC_PF_25:   {valid, rej_db, settle_us} = {1'b1, SFC_REJ_25, SFC_SETTLE_25_US};
      SFC_PF_20:   {valid, rej_db, settle_us} = {1'b1, SFC_REJ_20, SFC_SETTLE_20_US};
      SFC_PF_1667: {valid, rej_db, settle_us} = {1'b1, SFC_REJ_1667, SFC_SETTLE_1667_US};
      default:     {valid, rej_db, settle_us} = {1'b0, 7'd0, 16'd0};
    endcase
  end

endmodule : sfc_post_decode

/* File: core/sfc_rate_decode.sv */
`timescale 1ns/1ps
// Maps the output rate code and post-filter code to a sample rate.
module sfc_rate_decode
  import sfc_pkg::*;
(
  // Configuration view.
  sfc_cfg_if.dec cfg
);

  // Rate table for the output rate code, samples per second times one hundred.
  function automatic logic [25:0] sfc_code_rate(input logic [4:0] code);
    unique case (code)
      5'b00000: sfc_code_rate = {1'b1, 25'd25000000};
      5'b00001: sfc_code_rate = {1'b1, 25'd12500000};
      5'b00010: sfc_code_rate = {1'b1, 25'd6250000};
      5'b00011: sfc_code_rate = {1'b1, 25'd5000000};
      5'b00100: sfc_code_rate = {1'b1, 25'd2500000};
      default:  sfc_code_rate = {1'b0, 25'd0};
    endcase
  endfunction : sfc_code_rate

  // Post-filter rate table.
  function automatic logic [25:0] sfc_pf_rate(input logic [2:0] code);
    unique case (code)
      SFC_PF_27:   sfc_pf_rate = {1'b1, SFC_RATE_27};
      SFC_PF_25:   sfc_pf_rate = {1'b1, SFC_RATE_25};
      SFC_PF_20:   sfc_pf_rate = {1'b1, SFC_RATE_20};
      SFC_PF_1667: sfc_pf_rate = {1'b1, SFC_RATE_1667};
      default:     sfc_pf_rate = {1'b0, 25'd0};
    endcase
  endfunction : sfc_pf_rate

  // Post filter wins only with sinc5 plus sinc1 selected; direct mode gives no table rate.
  always_comb begin
    logic [25:0] r;
    r = 26'd0;
    if (cfg.direct) begin
      r = 26'd0;
    end else if (cfg.raw[SFC_POST_EN_BIT] &&
                 cfg.raw[SFC_TYPE_HI:SFC_TYPE_LO] == SFC_SINC5_SINC1) begin
      r = sfc_pf_rate(cfg.raw[SFC_POST_SEL_HI:SFC_POST_SEL_LO]);
    end else begin
      r = sfc_code_rate(cfg.raw[SFC_RATE_HI:SFC_RATE_LO]);
    end
    cfg.rate_valid = r[25];
    cfg.rate_x100  = r[24:0];
  end

endmodule : sfc_rate_decode
